// *** lsfs_pkg.sv ***
// package for the led string fault supervisor
package lsfs_pkg;
    // oscillator period count that makes up the disable time
    localparam int DISABLE_TIME_CYCLES = 32768;
    localparam int DISABLE_CNT_W = 16;
    localparam logic [DISABLE_CNT_W-1:0] DISABLE_CNT_MAX = 16'h7FFF;
    // default open-fault time-out in oscillator cycles
    localparam int OPEN_TIMEOUT_CYCLES = 1024;
    localparam int OPEN_CNT_W = 32;

    typedef struct packed {
        logic openString;
        logic refShort;
        logic nonrefShort;
        logic stringShort;
    } lsfs_cmp_t;

    typedef struct packed {
        logic out;
        logic oe;
    } lsfs_od_t;

    typedef enum logic [1:0] {
        LSFS_RUN = 2'b01,
        LSFS_OPEN = 2'b10
    } lsfs_state_t;
endpackage : lsfs_pkg

// *** lsfs_supervisor.sv ***
// fault supervision logic for the led string driver
`timescale 1ns/1ps
// Contract
// - open string forces gate drive low immediately
// - open fault releases secondary flag until time-out
// - after time-out re-enable drive and recheck open
// - repeat disable and retry while open persists
// - open detection ignores start-up fault blanking
// - reference led short from its comparator
// - non-reference led short from its comparator
// - led short releases secondary flag, keeps driving
// - led short indication is not latched
// - string short from its comparator
// - string or output short stops gate drive
// - string or output short releases primary flag
// - string short latched; long enable-low or power clears
// - primary flag pulled low overrides disable, keeps latch
// - disable time is fixed oscillator period count
// - flags pull down when clear, float on fault
// - open string from open comparator
module lsfs_supervisor #(
    parameter int OPEN_TIMEOUT = lsfs_pkg::OPEN_TIMEOUT_CYCLES,
    parameter int DISABLE_TIME = lsfs_pkg::DISABLE_TIME_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // analogue comparator results, asynchronous
    input wire lsfs_pkg::lsfs_cmp_t cmpIn,
    // enable pin and start-up blanking status
    input wire logic enablePin,
    input wire logic blankActive,
    // gate drive request from the regulator
    input wire logic regGateReq,
    // gate drive output
    output logic gateDriveOut,
    // open-drain fault flags
    input wire logic faultFlagPrimaryIn,
    output lsfs_pkg::lsfs_od_t faultFlagPrimary,
    output lsfs_pkg::lsfs_od_t faultFlagSecondary
);
    import lsfs_pkg::*;

    lsfs_cmp_t cmpMeta_r, cmpSync_r;
    logic [1:0] enMeta_r;
    logic enSync_r;
    logic ffInMeta_r, ffInSync_r;
    lsfs_state_t state_r;
    logic [OPEN_CNT_W-1:0] openCnt_r;
    logic [DISABLE_CNT_W-1:0] disCnt_r;
    logic shortLatch_r;
    logic gateDrive_r;
    logic ff1Float_r, ff2Float_r;
    logic [1:0] ff1RelDly_r;
    logic overrideSeen;
    logic openNow, ledShort, strShort, gateAllowed;

    // two-stage synchronisers, three stages for enable; first stage read only by second
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cmpMeta_r <= '0;
            cmpSync_r <= '0;
            enMeta_r <= 2'h0;
            enSync_r <= 1'b0;
            ffInMeta_r <= 1'b1;
            ffInSync_r <= 1'b1;
        end else begin
            cmpMeta_r <= cmpIn;
            cmpSync_r <= cmpMeta_r;
            enMeta_r <= {enMeta_r[0], enablePin};
            enSync_r <= enMeta_r[1];
            ffInMeta_r <= faultFlagPrimaryIn;
            ffInSync_r <= ffInMeta_r;
        end
    end

    // open acts regardless of blanking, shorts wait for it
    assign openNow = cmpSync_r.openString;
    assign ledShort = !blankActive && (cmpSync_r.refShort || cmpSync_r.nonrefShort);
    assign strShort = !blankActive && cmpSync_r.stringShort;

    // open fault retry machine
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r <= LSFS_RUN;
            openCnt_r <= '0;
        end else begin
            case (state_r)
                LSFS_RUN: begin
                    if (openNow) begin
                        state_r <= LSFS_OPEN;
                        openCnt_r <= '0;
                    end
                end
                LSFS_OPEN: begin
                    if (openCnt_r >= OPEN_CNT_W'(OPEN_TIMEOUT - 1)) begin
                        state_r <= LSFS_RUN;
                        openCnt_r <= '0;
                    end else begin
                        openCnt_r <= openCnt_r + 1'b1;
                    end
                end
                default: begin
                    state_r <= LSFS_RUN;
                    openCnt_r <= '0;
                end
            endcase
        end
    end

    // enable-low timer; enable low alone only pauses the gate
    always_ff @(posedge sys_clk) begin
        if (srst || enSync_r) begin
            disCnt_r <= '0;
        end else if (disCnt_r != DISABLE_CNT_W'(DISABLE_TIME - 1)) begin
            disCnt_r <= disCnt_r + 1'b1;
        end
    end

    // short latch: set wins over clear
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            shortLatch_r <= 1'b0;
        end else if (strShort) begin
            shortLatch_r <= 1'b1;
        end else if (!enSync_r && disCnt_r == DISABLE_CNT_W'(DISABLE_TIME - 1)) begin
            shortLatch_r <= 1'b0;
        end
    end

    // release delayed by the synchroniser depth, so our own pull-down
    // still seen on the wire right after a short is not an override
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ff1RelDly_r <= 2'h0;
        end else begin
            ff1RelDly_r <= {ff1RelDly_r[0], ff1Float_r};
        end
    end
    assign overrideSeen = ff1Float_r && ff1RelDly_r[1] && !ffInSync_r;

    // external pull-down on primary flag overrides the short disable
    assign gateAllowed = enSync_r && state_r == LSFS_RUN && !openNow
        && (!(shortLatch_r || strShort) || overrideSeen);

    // registered gate output; open comparator also gates it combinationally
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gateDrive_r <= 1'b0;
        end else begin
            gateDrive_r <= gateAllowed && regGateReq;
        end
    end
    assign gateDriveOut = gateDrive_r && !cmpSync_r.openString;

    // fault flags
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ff1Float_r <= 1'b0;
            ff2Float_r <= 1'b0;
        end else begin
            ff1Float_r <= shortLatch_r || strShort;
            ff2Float_r <= state_r == LSFS_OPEN || openNow || ledShort;
        end
    end

    // open drain: drive low when clear, release on fault
    assign faultFlagPrimary.out = 1'b0;
    assign faultFlagPrimary.oe = !ff1Float_r;
    assign faultFlagSecondary.out = 1'b0;
    assign faultFlagSecondary.oe = !ff2Float_r;
endmodule : lsfs_supervisor

// *** lsfs_supervisor_properties.sv ***
// port assertions for the fault supervisor
`timescale 1ns/1ps
module lsfs_supervisor_properties (
    // clock, reset, inputs
    input wire logic sys_clk, srst, enablePin, blankActive, faultFlagPrimaryIn,
    input wire lsfs_pkg::lsfs_cmp_t cmpIn,
    // outputs
    input wire logic gateDriveOut,
    input wire lsfs_pkg::lsfs_od_t faultFlagPrimary, faultFlagSecondary
);
    import lsfs_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    AST_OG: assert property (cmpIn.openString[*4] |-> !gateDriveOut) else $error("og");
    AST_OF: assert property ($rose(cmpIn.openString) |-> ##[1:4] !faultFlagSecondary.oe) else $error("of");
    AST_RS: assert property ((!blankActive && cmpIn.refShort)[*4] |-> !faultFlagSecondary.oe) else $error("rs");
    AST_NS: assert property ((!blankActive && cmpIn.nonrefShort)[*4] |-> !faultFlagSecondary.oe) else $error("ns");
    AST_SF: assert property ((!blankActive && cmpIn.stringShort)[*4] |-> !faultFlagPrimary.oe) else $error("sf");
    AST_SG: assert property (faultFlagPrimaryIn[*4] ##0 (!faultFlagPrimary.oe)[*2] |-> !gateDriveOut) else $error("sg");
    AST_LT: assert property (enablePin[*5] ##0 !faultFlagPrimary.oe |=> !faultFlagPrimary.oe) else $error("lt");
    AST_OD: assert property (!faultFlagPrimary.out && !faultFlagSecondary.out) else $error("od");
    AST_NP: assert property ($fell(faultFlagPrimary.oe) |-> (!gateDriveOut)[*3]) else $error("np");
    cover property (!gateDriveOut && cmpIn.openString);
    cover property ($fell(faultFlagPrimary.oe));
    cover property (gateDriveOut && !faultFlagPrimary.oe);
endmodule : lsfs_supervisor_properties
bind lsfs_supervisor lsfs_supervisor_properties u_props (.sys_clk, .srst, .enablePin, .blankActive,
    .faultFlagPrimaryIn, .cmpIn, .gateDriveOut, .faultFlagPrimary, .faultFlagSecondary);

// *** lsfs_host_model.sv ***
// far side: flag pull-ups and override pull-down
`timescale 1ns/1ps
module lsfs_host_model (
    // override request, flag pins
    input wire logic pullLow,
    input wire lsfs_pkg::lsfs_od_t faultFlagPrimary, faultFlagSecondary,
    // wire levels seen
    output logic faultFlagPrimaryIn, ff2Wire
);
    import lsfs_pkg::*;
    assign faultFlagPrimaryIn = !pullLow && !(faultFlagPrimary.oe && !faultFlagPrimary.out);
    assign ff2Wire = !(faultFlagSecondary.oe && !faultFlagSecondary.out);
endmodule : lsfs_host_model

// *** test_led_string_fault_supervisor.sv ***
// fault supervisor bench
`timescale 1ns/1ps
module test_led_string_fault_supervisor;
    import lsfs_pkg::*;
    localparam int TO = 8, DT = 16;
    logic sys_clk = 1'h0, srst = 1'h1, enablePin = 1'h0, blankActive = 1'h0, pullLow = 1'h0;
    logic gateDriveOut, faultFlagPrimaryIn, ff2Wire;
    lsfs_cmp_t cmpIn = '0;
    lsfs_od_t faultFlagPrimary, faultFlagSecondary;
    int failCount = 0, cmpCount = 0;
    wire [3:0] seen = {gateDriveOut, faultFlagPrimaryIn, ff2Wire, faultFlagPrimary.oe};
    always #10 sys_clk = ~sys_clk;
    lsfs_supervisor #(.OPEN_TIMEOUT(TO), .DISABLE_TIME(DT)) i_dut (.regGateReq(1'h1), .*);
    lsfs_host_model i_host (.*);
    // v = {comparators, enable, pull low, blank}
    task chk(input logic [6:0] v, input int n, input logic [3:0] exp);
        @(posedge sys_clk) {cmpIn, enablePin, pullLow, blankActive} <= v;
        repeat (n) @(posedge sys_clk);
        #1 cmpCount++;
        if (seen !== exp) begin
            failCount++;
            $display("[FAIL] %0t %h %h", $time, seen, exp);
        end
    endtask : chk
    task t_open;
        chk(7'h45, 4, 4'h3);
        chk(7'h45, 3 * TO, 4'h3);
        chk(7'h04, TO + 6, 4'h9);
    endtask : t_open
    task t_led;
        for (int i = 1; i < 3; i++) begin
            chk(7'(i * 16 + 4), 5, 4'hB);
            chk(7'h04, 5, 4'h9);
        end
    endtask : t_led
    // a short enable-low is dimming, not a clear
    task t_str;
        chk(7'h0C, 5, 4'h4);
        chk(7'h06, 6, 4'h8);
        chk(7'h00, DT - 6, 4'h4);
        chk(7'h04, 6, 4'h4);
        chk(7'h00, DT + 8, 4'h1);
        chk(7'h04, 6, 4'h9);
    endtask : t_str
    task complete_run;
        if (failCount == 0 && cmpCount > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    initial begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'h0;
        t_open();
        t_led();
        t_str();
        complete_run();
    end
endmodule : test_led_string_fault_supervisor
